// >>> pmt_host_model.sv
module pmt_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic idle_n,
   input wire logic act_n,
   input wire logic set_en,
   input wire logic [1:0] set_mode,
   output logic [1:0] pins
);
   // ****************************************
   // Mode pins {high, low}
   // ****************************************
   logic idle_q;
   logic act_q;
   // Edges only, so a pin held low does not re-trigger a move
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= 2'h1;
         idle_q <= 1'b1;
         act_q <= 1'b1;
      end else begin
         idle_q <= idle_n;
         act_q <= act_n;
         if (set_en) begin
            pins <= set_mode;
         end else if (idle_q && !idle_n) begin
            pins <= 2'h3;
         end else if (act_q && !act_n && pins == 2'h2) begin
            pins <= 2'h0;
         end
      end
   end
endmodule

// >>> pmt_mav.sv
module pmt_mav #(
   parameter int SAMPLE_W = 24,
   parameter int RESULT_W = 20,
   parameter int AVG_LOG2 = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic sample_valid,
   input wire logic signed [SAMPLE_W-1:0] sample,
   output logic [RESULT_W-1:0] result
);

   localparam int ACC_W = SAMPLE_W + AVG_LOG2;

   logic [ACC_W-1:0] acc_reg;
   logic [AVG_LOG2-1:0] n_reg;
   logic [RESULT_W-1:0] result_reg;
   wire [SAMPLE_W-1:0] mag = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : SAMPLE_W'(sample);
   wire [ACC_W-1:0] sum = acc_reg + ACC_W'(mag);
   wire last = &n_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= '0;
         n_reg <= '0;
         result_reg <= '0;
      end else if (!enable) begin
         acc_reg <= '0;
         n_reg <= '0;
      end else if (sample_valid) begin
         n_reg <= n_reg + 1'b1;
         acc_reg <= last ? '0 : sum;
         if (last) begin
            // Keep the upper bits of the mean; the low ones are noise
            result_reg <= sum[ACC_W-1 -: RESULT_W];
         end
      end
   end

   assign result = result_reg;

endmodule

// >>> pmt_phase_mon.sv
module pmt_phase_mon #(
   parameter int SAMPLE_W = 24,
   parameter int COUNT_W = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic clear,
   input wire logic sample_valid,
   input wire logic signed [SAMPLE_W-1:0] sample_p,
   input wire logic signed [SAMPLE_W-1:0] threshold,
   output logic [COUNT_W-1:0] count
);

   logic above_reg;
   logic [COUNT_W-1:0] count_reg;
   wire above_now = sample_p > threshold;
   // Only a fresh crossing counts, so a long peak is one event
   wire rise = enable && sample_valid && above_now && !above_reg;
   wire sat = &count_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         above_reg <= 1'b0;
         count_reg <= '0;
      end else if (clear || !enable) begin
         above_reg <= 1'b0;
         count_reg <= '0;
      end else begin
         if (sample_valid) begin
            above_reg <= above_now;
         end
         if (rise && !sat) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   assign count = count_reg;

endmodule

// >>> pmt_pkg.sv
package pmt_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int LINE_PERIOD_US = 20_000;
   localparam int LINE_CYCLES = LINE_PERIOD_US * (CLK_HZ / 1_000_000);
   localparam int TRANSITION_CYCLES = 16;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [3:0] ADDR_LPTC = 4'h0;
   localparam logic [3:0] ADDR_RETAINED = 4'h1;
   localparam logic [3:0] ADDR_SECOND_STATUS_WORD = 4'h2;
   localparam logic [3:0] ADDR_MAV_A = 4'h3;
   localparam logic [3:0] ADDR_MAV_B = 4'h4;
   localparam logic [3:0] ADDR_MAV_C = 4'h5;
   localparam logic [3:0] ADDR_COMMAND = 4'h6;
   localparam int PLC_MSB = 7;
   localparam int PLC_LSB = 3;
   localparam int THR_MSB = 2;
   localparam int THR_LSB = 0;
   localparam int DONE_BIT = 15;
   localparam int SOFT_RESET_BIT = 0;
   localparam logic [7:0] LPTC_RESET = 8'h07;
   localparam logic [7:0] RETAINED_RESET = 8'h00;

   // Encoded as {mode_pin_high, mode_pin_low}
   typedef enum logic [1:0] {
      MODE_REDUCED = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_SLEEP = 2'b11,
      MODE_LOW = 2'b10
   } pmt_mode_e;

   typedef enum logic [2:0] {
      ST_NORMAL = 3'b000,
      ST_TRANS = 3'b001,
      ST_REDUCED = 3'b011,
      ST_LOW = 3'b010,
      ST_SLEEP = 3'b110
   } pmt_state_e;

   function automatic pmt_mode_e decode_mode(input logic pin_high, input logic pin_low);
      return pmt_mode_e'({pin_high, pin_low});
   endfunction

endpackage

// >>> pmt_power_monitor.sv
module pmt_power_monitor #(
   parameter int SAMPLE_W = 24,
   parameter int LINE_CYCLES = pmt_pkg::LINE_CYCLES,
   parameter logic signed [SAMPLE_W-1:0] FULL_SCALE = 24'h7FFFFF
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic MODE_PIN_HIGH,
   input wire logic MODE_PIN_LOW,
   input wire logic SAMPLE_VALID,
   input wire logic signed [SAMPLE_W-1:0] PHASE_A_P,
   input wire logic signed [SAMPLE_W-1:0] PHASE_B_P,
   input wire logic signed [SAMPLE_W-1:0] PHASE_C_P,
   input wire logic REG_REQ,
   input wire logic REG_WE,
   input wire logic [3:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   output logic REG_ACK,
   output logic [23:0] REG_RDATA,
   output logic IDLE_INTERRUPT_N,
   output logic ACTIVITY_INTERRUPT_N,
   output logic [2:0] POWER_STATE
);

   localparam int COUNT_W = 6;
   localparam int TIMER_W = $clog2(LINE_CYCLES);
   localparam int TRANS_W = $clog2(pmt_pkg::TRANSITION_CYCLES);

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic [1:0] pin_high_sync_reg;
   logic [1:0] pin_low_sync_reg;
   wire rst_n = rst_sync_reg[1];

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         pin_high_sync_reg <= 2'b00;
         pin_low_sync_reg <= 2'b11;
      end else begin
         pin_high_sync_reg <= {pin_high_sync_reg[0], MODE_PIN_HIGH};
         pin_low_sync_reg <= {pin_low_sync_reg[0], MODE_PIN_LOW};
      end
   end

   // ****************************************
   // Mode sequencing
   // ****************************************
   pmt_pkg::pmt_state_e state_reg, state_next;
   logic [TRANS_W-1:0] trans_cnt_reg;
   wire pmt_pkg::pmt_mode_e pin_mode =
      pmt_pkg::decode_mode(pin_high_sync_reg[1], pin_low_sync_reg[1]);
   wire trans_end = (state_reg == pmt_pkg::ST_TRANS) &&
      (trans_cnt_reg == TRANS_W'(pmt_pkg::TRANSITION_CYCLES - 1));
   wire in_normal = state_reg == pmt_pkg::ST_NORMAL;
   wire in_reduced = state_reg == pmt_pkg::ST_REDUCED;
   wire in_low = state_reg == pmt_pkg::ST_LOW;

   always_comb begin
      state_next = state_reg;
      unique case (pin_mode)
         pmt_pkg::MODE_NORMAL: begin
            if (state_reg == pmt_pkg::ST_TRANS) begin
               state_next = trans_end ? pmt_pkg::ST_NORMAL : pmt_pkg::ST_TRANS;
            end else if (state_reg != pmt_pkg::ST_NORMAL) begin
               state_next = pmt_pkg::ST_TRANS;
            end
         end
         pmt_pkg::MODE_REDUCED: state_next = pmt_pkg::ST_REDUCED;
         pmt_pkg::MODE_LOW: state_next = pmt_pkg::ST_LOW;
         pmt_pkg::MODE_SLEEP: state_next = pmt_pkg::ST_SLEEP;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= pmt_pkg::ST_NORMAL;
         trans_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         trans_cnt_reg <= (state_reg == pmt_pkg::ST_TRANS) ? trans_cnt_reg + 1'b1 : '0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] lptc_reg;
   logic [7:0] retained_reg;
   logic done_reg;
   logic ack_reg;
   logic [23:0] rdata_reg;
   logic [19:0] mav [3];
   logic [23:0] rdata_next;

   wire [4:0] period_line_count = lptc_reg[pmt_pkg::PLC_MSB:pmt_pkg::PLC_LSB];
   wire [2:0] threshold_eighths = lptc_reg[pmt_pkg::THR_MSB:pmt_pkg::THR_LSB];
   // Full register access only in normal; reduced mode serves the results alone
   wire mav_addr = (REG_ADDR == pmt_pkg::ADDR_MAV_A) || (REG_ADDR == pmt_pkg::ADDR_MAV_B) ||
      (REG_ADDR == pmt_pkg::ADDR_MAV_C);
   wire access_ok = in_normal || (in_reduced && !REG_WE && mav_addr);
   wire take = REG_REQ && access_ok;
   wire wr = take && REG_WE;
   wire soft_reset = wr && (REG_ADDR == pmt_pkg::ADDR_COMMAND) &&
      REG_WDATA[pmt_pkg::SOFT_RESET_BIT];
   wire done_clear = wr && (REG_ADDR == pmt_pkg::ADDR_SECOND_STATUS_WORD) && REG_WDATA[pmt_pkg::DONE_BIT];
   wire general_reset = soft_reset || (state_reg == pmt_pkg::ST_TRANS);

   always_comb begin
      rdata_next = '0;
      unique case (REG_ADDR)
         pmt_pkg::ADDR_LPTC: rdata_next = {16'h0000, lptc_reg};
         pmt_pkg::ADDR_RETAINED: rdata_next = {16'h0000, retained_reg};
         pmt_pkg::ADDR_SECOND_STATUS_WORD: rdata_next = {8'h00, done_reg, 15'h0000};
         pmt_pkg::ADDR_MAV_A: rdata_next = {4'h0, mav[0]};
         pmt_pkg::ADDR_MAV_B: rdata_next = {4'h0, mav[1]};
         pmt_pkg::ADDR_MAV_C: rdata_next = {4'h0, mav[2]};
         default: rdata_next = '0;
      endcase
   end

   // Hardware reset loads LPTC_RESET (07) and RETAINED_RESET (00) into the retained pair
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         lptc_reg <= pmt_pkg::LPTC_RESET;
         retained_reg <= pmt_pkg::RETAINED_RESET;
      end else if (wr && in_normal) begin
         // Neither soft reset nor mode changes touch these
         if (REG_ADDR == pmt_pkg::ADDR_LPTC) begin
            lptc_reg <= REG_WDATA[7:0];
         end
         if (REG_ADDR == pmt_pkg::ADDR_RETAINED) begin
            retained_reg <= REG_WDATA[7:0];
         end
      end
   end

   // Completion of a transition sets the flag; setting beats a clear in the same cycle
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         done_reg <= 1'b0;
      end else if (trans_end) begin
         done_reg <= 1'b1;
      end else if (done_clear || soft_reset) begin
         done_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= take;
         if (take && !REG_WE) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // ****************************************
   // Low-power current monitor
   // ****************************************
   logic [TIMER_W-1:0] cyc_reg;
   logic [4:0] line_reg;
   logic low_prev_reg;
   logic idle_reg;
   logic act_reg;
   logic [COUNT_W-1:0] count [3];
   logic signed [SAMPLE_W-1:0] sample_p [3];

   wire [SAMPLE_W+2:0] thr_prod = (SAMPLE_W + 3)'(FULL_SCALE) * (SAMPLE_W + 3)'(threshold_eighths);
   wire signed [SAMPLE_W-1:0] threshold = thr_prod[SAMPLE_W+2:3];
   wire line_end = cyc_reg == TIMER_W'(LINE_CYCLES - 1);
   wire period_end = in_low && low_prev_reg && line_end && (line_reg == period_line_count);
   wire restart = (in_low && !low_prev_reg) || period_end;
   wire [COUNT_W-1:0] limit = COUNT_W'(period_line_count) + 1'b1;
   wire any_active = (count[0] >= limit) || (count[1] >= limit) || (count[2] >= limit);

   assign sample_p[0] = PHASE_A_P;
   assign sample_p[1] = PHASE_B_P;
   assign sample_p[2] = PHASE_C_P;

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         cyc_reg <= '0;
         line_reg <= '0;
         low_prev_reg <= 1'b0;
      end else begin
         low_prev_reg <= in_low;
         if (restart || !in_low) begin
            cyc_reg <= '0;
            line_reg <= '0;
         end else if (line_end) begin
            cyc_reg <= '0;
            line_reg <= line_reg + 1'b1;
         end else begin
            cyc_reg <= cyc_reg + 1'b1;
         end
      end
   end

   // Verdict holds until the next period ends or the mode changes
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= 1'b0;
         act_reg <= 1'b0;
      end else if (!in_low) begin
         idle_reg <= 1'b0;
         act_reg <= 1'b0;
      end else if (period_end) begin
         idle_reg <= !any_active;
         act_reg <= any_active;
      end
   end

   // ****************************************
   // Per-phase blocks
   // ****************************************
   for (genvar p = 0; p < 3; p++) begin : g_phase
      // Only the positive terminal feeds the detector
      pmt_phase_mon #(
         .SAMPLE_W(SAMPLE_W),
         .COUNT_W(COUNT_W)
      ) u_mon (
         .clk(CLK_SYS),
         .rst_n(rst_n),
         .enable(in_low),
         .clear(restart),
         .sample_valid(SAMPLE_VALID),
         .sample_p(sample_p[p]),
         .threshold(threshold),
         .count(count[p])
      );

      // Stopped in low-power and sleep to save current
      pmt_mav #(
         .SAMPLE_W(SAMPLE_W),
         .RESULT_W(20),
         .AVG_LOG2(8)
      ) u_mav (
         .clk(CLK_SYS),
         .rst_n(rst_n),
         .enable(in_normal || in_reduced),
         .sample_valid(SAMPLE_VALID),
         .sample(sample_p[p]),
         .result(mav[p])
      );
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic idle_n_reg;
   logic act_n_reg;

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         idle_n_reg <= 1'b1;
         act_n_reg <= 1'b1;
      end else begin
         idle_n_reg <= !idle_reg;
         act_n_reg <= !(act_reg || (done_reg && !general_reset));
      end
   end

   assign IDLE_INTERRUPT_N = idle_n_reg;
   assign ACTIVITY_INTERRUPT_N = act_n_reg;
   assign REG_ACK = ack_reg;
   assign REG_RDATA = rdata_reg;
   assign POWER_STATE = state_reg;

endmodule

// >>> pmt_power_monitor_monitor.sv
module pmt_power_monitor_monitor #(
   parameter int LINE_CYCLES = pmt_pkg::LINE_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic MODE_PIN_HIGH,
   input wire logic MODE_PIN_LOW,
   input wire logic REG_REQ,
   input wire logic REG_WE,
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_ACK,
   input wire logic IDLE_INTERRUPT_N,
   input wire logic ACTIVITY_INTERRUPT_N,
   input wire logic [2:0] POWER_STATE
);
   // ****************************************
   // Cycle counters for the transition and low-power states
   // ****************************************
   int trans_cnt;
   int low_cnt;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         trans_cnt <= 0;
         low_cnt <= 0;
      end else begin
         trans_cnt <= (POWER_STATE == 3'h1) ? trans_cnt + 1 : 0;
         low_cnt <= (POWER_STATE == 3'h2) ? low_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // ****************************************
   // Properties
   // ****************************************
   a_ack_has_cause: assert property (
      REG_ACK |-> $past(REG_REQ) && !($past(POWER_STATE) inside {3'h1, 3'h2, 3'h6}))
      else $error("ack without an allowed request");
   a_reduced_reads_only: assert property (
      REG_ACK && $past(POWER_STATE) == 3'h3 |-> !$past(REG_WE) && $past(REG_ADDR) inside {[4'h3:4'h5]})
      else $error("reduced mode answered a forbidden access");
   a_normal_acks: assert property (
      REG_REQ && POWER_STATE == 3'h0 |=> REG_ACK)
      else $error("normal mode request not answered");
   a_trans_length: assert property (
      POWER_STATE != 3'h1 && trans_cnt != 0 |-> trans_cnt == 16 && POWER_STATE == 3'h0)
      else $error("transition length wrong");
   a_no_early_verdict: assert property (
      POWER_STATE == 3'h2 && low_cnt < LINE_CYCLES |-> IDLE_INTERRUPT_N && ACTIVITY_INTERRUPT_N)
      else $error("verdict before the period ended");
   a_idle_from_low: assert property (
      $fell(IDLE_INTERRUPT_N) |-> POWER_STATE == 3'h2)
      else $error("idle interrupt outside low power");
   a_sleep_quiet: assert property (
      (POWER_STATE == 3'h6) [*3] |-> IDLE_INTERRUPT_N && ACTIVITY_INTERRUPT_N && !REG_ACK)
      else $error("activity while asleep");
   a_mode_decode: assert property (
      $stable({MODE_PIN_HIGH, MODE_PIN_LOW}) [*5] |->
         ({MODE_PIN_HIGH, MODE_PIN_LOW} == 2'h0 && POWER_STATE == 3'h3) ||
         ({MODE_PIN_HIGH, MODE_PIN_LOW} == 2'h2 && POWER_STATE == 3'h2) ||
         ({MODE_PIN_HIGH, MODE_PIN_LOW} == 2'h3 && POWER_STATE == 3'h6) ||
         ({MODE_PIN_HIGH, MODE_PIN_LOW} == 2'h1 && POWER_STATE inside {3'h0, 3'h1}))
      else $error("state does not follow mode pins");
   c_idle: cover property ($fell(IDLE_INTERRUPT_N));
   c_activity: cover property ($fell(ACTIVITY_INTERRUPT_N) && POWER_STATE == 3'h2);
   c_transition: cover property (trans_cnt == 16);
endmodule

bind pmt_power_monitor pmt_power_monitor_monitor #(.LINE_CYCLES(LINE_CYCLES)) i_mon (
   .CLK_SYS, .RST_N, .MODE_PIN_HIGH, .MODE_PIN_LOW, .REG_REQ, .REG_WE, .REG_ADDR,
   .REG_ACK, .IDLE_INTERRUPT_N, .ACTIVITY_INTERRUPT_N, .POWER_STATE);

// >>> pmt_power_monitor_tb_top.sv
module pmt_power_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LC = 20;
   localparam int P = 2 * LC;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sv = 1'b0, hi = 1'b0, req = 1'b0, we = 1'b0, set_en = 1'b0, ok = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [23:0] amp = 24'h000000, pa = 24'h000000, pb = 24'h000000, got;
   logic [1:0] set_mode = 2'h1, pins;
   logic ack, idle_n, act_n;
   logic [23:0] rdata;
   logic [2:0] state;
   int fail_count = 0, tests_run = 0, cyc = 0, t0, n;

   pmt_power_monitor #(.LINE_CYCLES(LC)) i_dut (.CLK_SYS(clk), .RST_N(rst_n),
      .MODE_PIN_HIGH(pins[1]), .MODE_PIN_LOW(pins[0]), .SAMPLE_VALID(sv),
      .PHASE_A_P(pa), .PHASE_B_P(pb), .PHASE_C_P(pb), .REG_REQ(req), .REG_WE(we),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_ACK(ack), .REG_RDATA(rdata),
      .IDLE_INTERRUPT_N(idle_n), .ACTIVITY_INTERRUPT_N(act_n), .POWER_STATE(state));
   pmt_host_model i_host (.clk(clk), .rst_n(rst_n), .idle_n(idle_n), .act_n(act_n),
      .set_en(set_en), .set_mode(set_mode), .pins(pins));

   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sv <= ~sv;
      if (sv)
         hi <= ~hi;
      pa <= hi ? amp : 24'h000000;
      // Large negative swing must never count as a crossing
      pb <= hi ? 24'hA00000 : 24'h000000;
   end

   // ****************************************
   // Drivers and compare
   // ****************************************
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d);
      ok = 1'b0;
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            got = rdata;
         end
      end
      req <= 1'b0;
      @(posedge clk);
   endtask
   task automatic xfer(input string nm, input logic w, input logic [3:0] a,
                       input logic [15:0] d, input logic eok, input logic [23:0] exp);
      access(w, a, d);
      check({nm, " ack"}, {23'h0, eok}, {23'h0, ok});
      if (eok && !w)
         check(nm, exp, got);
   endtask
   task automatic mode(input logic [1:0] m);
      @(posedge clk);
      set_en <= 1'b1;
      set_mode <= m;
      t0 = cyc;
      @(posedge clk);
      set_en <= 1'b0;
   endtask
   task automatic wait_for(input int k, input logic [2:0] s);
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         if ((k == 0 && idle_n === 1'b0) || (k == 1 && act_n === 1'b0) || (k == 2 && state === s))
            break;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_defaults();
      xfer("lptc", 1'b0, 4'h0, 16'h0000, 1'b1, 24'h000007);
      xfer("retained", 1'b0, 4'h1, 16'h0000, 1'b1, 24'h000000);
      xfer("status", 1'b0, 4'h2, 16'h0000, 1'b1, 24'h000000);
      xfer("unmapped", 1'b0, 4'hF, 16'h0000, 1'b1, 24'h000000);
   endtask
   task automatic t_soft_reset();
      xfer("lptc wr", 1'b1, 4'h0, 16'h000C, 1'b1, 24'h0);
      xfer("ret wr", 1'b1, 4'h1, 16'h005A, 1'b1, 24'h0);
      xfer("soft rst", 1'b1, 4'h6, 16'h0001, 1'b1, 24'h0);
      xfer("lptc kept", 1'b0, 4'h0, 16'h0000, 1'b1, 24'h00000C);
      xfer("ret kept", 1'b0, 4'h1, 16'h0000, 1'b1, 24'h00005A);
   endtask
   task automatic t_idle_sleep();
      amp = 24'h200000;
      mode(2'h2);
      wait_for(2, 3'h2);
      xfer("low rd", 1'b0, 4'h0, 16'h0000, 1'b0, 24'h0);
      wait_for(0, 3'h0);
      check("idle time", 24'h1, {23'h0, (cyc - t0 >= P) && (cyc - t0 <= P + 10)});
      wait_for(2, 3'h6);
      check("sleep", 24'h6, {21'h0, state});
      xfer("sleep rd", 1'b0, 4'h0, 16'h0000, 1'b0, 24'h0);
   endtask
   task automatic t_activity();
      amp = 24'h500000;
      mode(2'h2);
      xfer("low wr", 1'b1, 4'h0, 16'h00FF, 1'b0, 24'h0);
      wait_for(1, 3'h0);
      check("act time", 24'h1, {23'h0, (cyc - t0 >= P) && (cyc - t0 <= P + 10)});
      wait_for(2, 3'h3);
      check("reduced", 24'h3, {21'h0, state});
      access(1'b0, 4'h3, 16'h0000);
      check("mav ack", 24'h1, {23'h0, ok});
      xfer("red lptc", 1'b0, 4'h0, 16'h0000, 1'b0, 24'h0);
      xfer("red wr", 1'b1, 4'h3, 16'h0000, 1'b0, 24'h0);
   endtask
   task automatic t_back_normal();
      mode(2'h1);
      wait_for(2, 3'h1);
      wait_for(2, 3'h0);
      check("trans cycles", 24'h00000F, n[23:0]);
      xfer("done", 1'b0, 4'h2, 16'h0000, 1'b1, 24'h008000);
      check("act on done", 24'h0, {23'h0, act_n});
      xfer("done clr", 1'b1, 4'h2, 16'h8000, 1'b1, 24'h0);
      xfer("done gone", 1'b0, 4'h2, 16'h0000, 1'b1, 24'h000000);
      check("act released", 24'h1, {23'h0, act_n});
      xfer("lptc kept", 1'b0, 4'h0, 16'h0000, 1'b1, 24'h00000C);
      xfer("ret kept", 1'b0, 4'h1, 16'h0000, 1'b1, 24'h00005A);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      // Reset stays high from here on, sleep included
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_defaults();
      t_soft_reset();
      t_idle_sleep();
      t_activity();
      t_back_normal();
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
